// ---- rate_conv_defs.svh ----
// Register indices, field positions, reset values and counts.
// What this block does
// - A new output pair every 2*(N+1) crystal ticks, N from rate field.
// - Rate field takes any value 0 to 0xfff, divider 1 to 4096.
// - Converter runs only while enable bit 12 of config is one.
// - Each stored output pair raises an interrupt request.
// - Right-full bit 14, left-full bit 13 set on update, clear on read of that side's high register.
// - Overrun bit 15 sets when update hits unread output data.
// - Each 24-bit sample splits into bits 23:8 and bits 7:0 registers.
// - Outputs count as valid only after 19 input samples since start.
`ifndef RATE_CONV_DEFS_SVH
`define RATE_CONV_DEFS_SVH
`define ADDR_W 18
`define IDX_CONFIG 16'hfec6
`define IDX_LEFT_LO 16'hfec7
`define IDX_LEFT_HI 16'hfec8
`define IDX_RIGHT_LO 16'hfec9
`define IDX_RIGHT_HI 16'hfeca
`define IDX_IRQ_STAT 16'hfed0
`define IDX_IRQ_MASK 16'hfed1
`define CFG_ORUN_BIT 15
`define CFG_RFULL_BIT 14
`define CFG_LFULL_BIT 13
`define CFG_ENA_BIT 12
`define CFG_FS_MSB 11
`define REG_RESET 16'h0000
`define FS_W 12
`define IN_DELAY 19
`define IRQ_NEW_BIT 0
`define IRQ_ORUN_BIT 1
`define IRQ_W 2
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ---- rate_conv_pkg.sv ----
// Types shared by the rate converter.
package rate_conv_pkg;
  // One stereo sample pair.
  typedef struct packed {
    logic [23:0] left;
    logic [23:0] right;
  } stereo_s;
endpackage

// ---- audio_rate_upconverter.sv ----
// Stereo upward sample rate converter with an AXI4-Lite register slave.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/100ps
`include "rate_conv_defs.svh"
module audio_rate_upconverter
  import rate_conv_pkg::*;
#(
  parameter int FS_W = `FS_W,
  parameter int IN_DELAY = `IN_DELAY
)(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic crystal_clock,
  input wire logic dac_in_valid,
  input wire stereo_s dac_in,
  input wire logic [`ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq
);

  // The divider field and the data layout are fixed by the register map.
  if (FS_W != 12 || IN_DELAY < 1 || IN_DELAY > 255)
  begin : g_bad_param
    $error("audio_rate_upconverter: unsupported parameter value");
  end

  logic en_q;
  logic [FS_W-1:0] fs_q;
  logic [FS_W:0] cnt_q;
  logic lfull_q, rfull_q, orun_q;
  logic [15:0] left_hi_q, left_lo_q, right_hi_q, right_lo_q;
  logic [`IRQ_W-1:0] stat_q, mask_q;
  logic [7:0] seen_q;
  logic primed, out_tick;
  logic [FS_W:0] cnt_top;
  stereo_s dly_q [IN_DELAY];
  stereo_s out_pair;
  logic wr_go, rd_go;
  logic [15:0] wr_idx, rd_idx, wd, rd_val;
  logic wr_ok, rd_hit;

  // Write is taken when address and data have both been accepted.
  assign wr_go = s_axi_awready && s_axi_awvalid && s_axi_wvalid;
  assign rd_go = s_axi_arready && s_axi_arvalid;
  assign wr_idx = s_axi_awaddr[`ADDR_W-1:2];
  assign rd_idx = s_axi_araddr[`ADDR_W-1:2];
  assign wr_ok = (s_axi_awaddr[1:0] == 2'h0);
  assign wd = s_axi_wdata[15:0];

  // interval top
  // The counter runs 0..2N+1, so one pass spans 2*(N+1) crystal ticks.
  assign cnt_top = {fs_q, 1'b1};
  assign out_tick = en_q && crystal_clock && (cnt_q == cnt_top) && primed;
  assign primed = (seen_q == 8'(IN_DELAY));
  assign out_pair = dly_q[IN_DELAY-1];

  // Write channel handshake: both ready together, one write at a time.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                       !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                      !s_axi_bvalid;
    end
  end

  // Write response; unmapped or unaligned addresses answer SLVERR.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_ok && (wr_idx == `IDX_CONFIG ||
                      wr_idx == `IDX_LEFT_LO || wr_idx == `IDX_LEFT_HI ||
                      wr_idx == `IDX_RIGHT_LO || wr_idx == `IDX_RIGHT_HI ||
                      wr_idx == `IDX_IRQ_STAT || wr_idx == `IDX_IRQ_MASK)) ?
                     `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read decode of the registers; reserved bits read as zero.
  always_comb
  begin
    rd_hit = (s_axi_araddr[1:0] == 2'h0);
    case (rd_idx)
      `IDX_CONFIG: rd_val = {orun_q, rfull_q, lfull_q, en_q, fs_q};
      `IDX_LEFT_LO: rd_val = left_lo_q;
      `IDX_LEFT_HI: rd_val = left_hi_q;
      `IDX_RIGHT_LO: rd_val = right_lo_q;
      `IDX_RIGHT_HI: rd_val = right_hi_q;
      `IDX_IRQ_STAT: rd_val = {14'h0000, stat_q};
      `IDX_IRQ_MASK: rd_val = {14'h0000, mask_q};
      default:
      begin
        rd_val = 16'h0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  // Read channel: address taken, data one cycle later, held until rready.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_hit ? {16'h0000, rd_val} : 32'h00000000;
        s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // Configuration: enable and rate field are written by software.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      en_q <= 1'b0;
      fs_q <= FS_W'(`REG_RESET);
    end
    else if (wr_go && wr_ok && wr_idx == `IDX_CONFIG)
    begin
      if (s_axi_wstrb[0])
        fs_q[7:0] <= wd[7:0];
      if (s_axi_wstrb[1])
      begin
        fs_q[`CFG_FS_MSB:8] <= wd[`CFG_FS_MSB:8];
        en_q <= wd[`CFG_ENA_BIT];
      end
    end
  end

  // interval counter
  // Counting only on crystal ticks makes the interval exact in crystal time.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      cnt_q <= '0;
    else if (!en_q)
      cnt_q <= '0;
    else if (crystal_clock)
      cnt_q <= (cnt_q >= cnt_top) ? '0 : cnt_q + 1'b1;
  end

  // input delay line
  // Input pairs walk a delay line; output is trusted only once it is full.
  for (genvar i = 0; i < IN_DELAY; i++)
  begin : g_dly
    always_ff @(posedge clk or negedge rst_b)
    begin
      if (!rst_b)
        dly_q[i] <= '0;
      else if (en_q && dac_in_valid)
        dly_q[i] <= (i == 0) ? dac_in : dly_q[(i == 0) ? 0 : i-1];
    end
  end

  // start-up count
  // The count restarts whenever the converter is disabled.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      seen_q <= 8'h00;
    else if (!en_q)
      seen_q <= 8'h00;
    else if (dac_in_valid && !primed)
      seen_q <= seen_q + 8'h01;
  end

  // sample split
  // Low byte sits in the upper byte of the low register.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      left_hi_q <= `REG_RESET;
      left_lo_q <= `REG_RESET;
      right_hi_q <= `REG_RESET;
      right_lo_q <= `REG_RESET;
    end
    else if (out_tick)
    begin
      left_hi_q <= out_pair.left[23:8];
      left_lo_q <= {out_pair.left[7:0], 8'h00};
      right_hi_q <= out_pair.right[23:8];
      right_lo_q <= {out_pair.right[7:0], 8'h00};
    end
    else if (wr_go && wr_ok)
    begin
      // Software may overwrite the holding registers; flags do not move.
      case (wr_idx)
        `IDX_LEFT_LO: left_lo_q <= wd;
        `IDX_LEFT_HI: left_hi_q <= wd;
        `IDX_RIGHT_LO: right_lo_q <= wd;
        `IDX_RIGHT_HI: right_hi_q <= wd;
        default: left_lo_q <= left_lo_q;
      endcase
    end
  end

  // full flags
  // A fresh update in the same cycle as a read wins over the clear.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lfull_q <= 1'b0;
      rfull_q <= 1'b0;
    end
    else if (out_tick)
    begin
      lfull_q <= 1'b1;
      rfull_q <= 1'b1;
    end
    else if (rd_go && rd_hit)
    begin
      if (rd_idx == `IDX_LEFT_HI)
        lfull_q <= 1'b0;
      if (rd_idx == `IDX_RIGHT_HI)
        rfull_q <= 1'b0;
    end
  end

  // overrun flag
  // Cleared by writing one to bit 15 of the config register.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      orun_q <= 1'b0;
    else if (out_tick && (lfull_q || rfull_q))
      orun_q <= 1'b1;
    else if (wr_go && wr_ok && wr_idx == `IDX_CONFIG && s_axi_wstrb[1] &&
             wd[`CFG_ORUN_BIT])
      orun_q <= 1'b0;
  end

  // interrupt status
  // Sticky status, write one to clear; a new event beats the clear.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stat_q <= '0;
      mask_q <= '0;
    end
    else
    begin
      for (int b = 0; b < `IRQ_W; b++)
        if (wr_go && wr_ok && wr_idx == `IDX_IRQ_STAT && s_axi_wstrb[0] &&
            wd[b])
          stat_q[b] <= 1'b0;
      if (out_tick)
        stat_q[`IRQ_NEW_BIT] <= 1'b1;
      if (out_tick && (lfull_q || rfull_q))
        stat_q[`IRQ_ORUN_BIT] <= 1'b1;
      if (wr_go && wr_ok && wr_idx == `IDX_IRQ_MASK && s_axi_wstrb[0])
        mask_q <= wd[`IRQ_W-1:0];
    end
  end

  // interrupt line
  // Registered so the output is glitch free; costs one cycle of latency.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      irq <= 1'b0;
    else
      irq <= |(stat_q & mask_q);
  end

  // Checks of the behaviour above.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  property p_tick_top;
    out_tick |-> cnt_q == {fs_q, 1'b1} && crystal_clock;
  endproperty
  a_tick_top: assert property (p_tick_top)
    else $error("output pair taken off the interval top");
  property p_cnt_wrap;
    en_q && crystal_clock && cnt_q == cnt_top ##1 en_q |-> cnt_q == '0;
  endproperty
  a_cnt_wrap: assert property (p_cnt_wrap)
    else $error("interval counter did not wrap to zero");
  property p_idle;
    !en_q |-> !out_tick ##1 (cnt_q == '0 || en_q);
  endproperty
  a_idle: assert property (p_idle)
    else $error("disabled converter still active");
  property p_run_only_enabled;
    !en_q |=> !$rose(lfull_q) && !$rose(rfull_q) && !$rose(orun_q);
  endproperty
  a_run_only_enabled: assert property (p_run_only_enabled)
    else $error("converter changed flags while disabled");
  property p_full_set;
    out_tick |=> lfull_q && rfull_q && stat_q[`IRQ_NEW_BIT];
  endproperty
  a_full_set: assert property (p_full_set)
    else $error("full flags not set by an update");
  property p_orun;
    out_tick && (lfull_q || rfull_q) |=> orun_q;
  endproperty
  a_orun: assert property (p_orun)
    else $error("overrun not flagged");
  property p_split;
    out_tick |=> left_hi_q == $past(out_pair.left[23:8]) &&
      right_lo_q[15:8] == $past(out_pair.right[7:0]);
  endproperty
  a_split: assert property (p_split)
    else $error("sample split wrong");
  property p_primed;
    en_q && dac_in_valid && !primed |=> seen_q == $past(seen_q) + 8'h01;
  endproperty
  a_primed: assert property (p_primed)
    else $error("start-up count missed an input strobe");
  // The mask must still be set when the status bit lands to expect the line.
  property p_irq;
    out_tick && mask_q[`IRQ_NEW_BIT] ##1 mask_q[`IRQ_NEW_BIT] |-> ##1 irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised for new pair");

  c_tick: cover property (out_tick);
  c_overrun: cover property (out_tick && lfull_q);
  c_read_clear: cover property (lfull_q ##1 !lfull_q);
endmodule // audio_rate_upconverter

// ---- dac_source.sv ----
// Model of the DAC input sample path and the crystal tick source.
`timescale 1ns/100ps
module dac_source
  import rate_conv_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic run,
  output logic crystal_clock,
  output logic dac_in_valid,
  output stereo_s dac_in
);
  logic [7:0] tick_q;

  // Crystal ticks run free, one every eight clocks.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tick_q <= 8'h00;
      crystal_clock <= 1'b0;
    end
    else
    begin
      tick_q <= tick_q + 8'h01;
      crystal_clock <= (tick_q[2:0] == 3'h7);
    end
  end

  // One pair every 256 clocks; between strobes the data lines toggle,
  // so a design that samples off the strobe sees inverted data on every other clock.
  // slower than output
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dac_in_valid <= 1'b0;
      dac_in <= '0;
    end
    else if (run && tick_q == 8'hff)
    begin
      dac_in_valid <= 1'b1;
      dac_in <= {24'($urandom), 24'($urandom)};
    end
    else
    begin
      dac_in_valid <= 1'b0;
      dac_in <= ~dac_in;
    end
  end
endmodule // dac_source

// ---- audio_rate_upconverter_tb_top.sv ----
// Self-checking bench for the audio rate upconverter.
`timescale 1ns/100ps
`include "rate_conv_defs.svh"
module audio_rate_upconverter_tb_top
  import rate_conv_pkg::*;
;
  localparam logic [17:0] CFG = {`IDX_CONFIG, 2'b00};
  localparam logic [17:0] LLO = {`IDX_LEFT_LO, 2'b00};
  localparam logic [17:0] LHI = {`IDX_LEFT_HI, 2'b00};
  localparam logic [17:0] RLO = {`IDX_RIGHT_LO, 2'b00};
  localparam logic [17:0] RHI = {`IDX_RIGHT_HI, 2'b00};
  localparam logic [17:0] STA = {`IDX_IRQ_STAT, 2'b00};
  localparam logic [17:0] MSK = {`IDX_IRQ_MASK, 2'b00};
  localparam int D = 2;
  logic clk = 0, rst_b = 0, run = 0, xtal, dv, irq;
  logic aw_valid = 0, w_valid = 0, b_ready = 0, ar_valid = 0;
  logic r_ready = 0, aw_ready, w_ready, b_valid, ar_ready, r_valid;
  logic [17:0] aw_addr = 0, ar_addr = 0;
  logic [31:0] w_data = 0, r_data, rdat, d;
  logic [1:0] b_resp, r_resp, resp, wresp;
  logic [3:0] w_strb = 4'hf;
  stereo_s din, s;
  stereo_s hist[$];
  int cyc = 0, n_errors = 0, samples_checked = 0;

  dac_source src (.clk(clk), .rst_b(rst_b), .run(run),
    .crystal_clock(xtal), .dac_in_valid(dv), .dac_in(din));

  // Short start-up delay keeps the run brief.
  audio_rate_upconverter #(.IN_DELAY(D)) dut (.clk(clk), .rst_b(rst_b),
    .crystal_clock(xtal), .dac_in_valid(dv), .dac_in(din),
    .s_axi_awaddr(aw_addr), .s_axi_awvalid(aw_valid),
    .s_axi_awready(aw_ready), .s_axi_wdata(w_data),
    .s_axi_wstrb(w_strb), .s_axi_wvalid(w_valid), .s_axi_wready(w_ready),
    .s_axi_bresp(b_resp), .s_axi_bvalid(b_valid),
    .s_axi_bready(b_ready), .s_axi_araddr(ar_addr),
    .s_axi_arvalid(ar_valid), .s_axi_arready(ar_ready),
    .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_valid),
    .s_axi_rready(r_ready), .irq(irq));

  always #4 clk = ~clk;

  // Input history for expectations, and the hang guard.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (dv === 1'b1)
      hist.push_back(din);
    if (cyc == 20000)
    begin
      n_errors++;
      conclude();
    end
  end

  task automatic conclude();
    if (n_errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask

  // Bus tasks end one edge after release, so no strobe is set twice.
  task automatic wr(input logic [17:0] a, input logic [31:0] v);
    aw_addr <= a;
    w_data <= v;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    b_ready <= 1'b1;
    do @(posedge clk); while (aw_ready !== 1'b1);
    aw_valid <= 1'b0;
    w_valid <= 1'b0;
    do @(posedge clk); while (b_valid !== 1'b1);
    wresp = b_resp;
    b_ready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [17:0] a);
    ar_addr <= a;
    ar_valid <= 1'b1;
    r_ready <= 1'b1;
    do @(posedge clk); while (ar_ready !== 1'b1);
    ar_valid <= 1'b0;
    do @(posedge clk); while (r_valid !== 1'b1);
    rdat = r_data;
    resp = r_resp;
    r_ready <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rc(input logic [17:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask

  function automatic logic [31:0] hi(input logic [23:0] v);
    return {16'h0, v[23:8]};
  endfunction

  function automatic logic [31:0] lo(input logic [23:0] v);
    return {16'h0, v[7:0], 8'h00};
  endfunction

  // Times three updates by the interrupt, clearing status in between.
  task automatic gap(input logic [11:0] n);
    int t[3];
    wr(CFG, {19'h0, 1'b1, n});
    for (int i = 0; i < 3; i++)
    begin
      while (irq !== 1'b1) @(posedge clk);
      t[i] = cyc;
      wr(STA, 32'h3);
      while (irq !== 1'b0) @(posedge clk);
    end
    chk(32'(t[2] - t[1]), 32'(2 * (n + 1) * 8));
  endtask

  initial
  begin
    void'($urandom(55286));
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rc(CFG, 32'h0);
    rc(LLO, 32'h0);
    rc(RHI, 32'h0);
    rd(18'h00100);
    chk({30'h0, resp}, {30'h0, `RESP_SLVERR});
    repeat (4)
    begin
      d = $urandom;
      wr(LHI, d);
      wr(RHI, ~d);
      rc(LHI, {16'h0, d[15:0]});
      rc(RHI, {16'h0, ~d[15:0]});
    end
    wr(CFG, 32'hfff);
    chk({30'h0, wresp}, {30'h0, `RESP_OKAY});
    rc(CFG, 32'hfff);
    // A low-lane-only write moves the low rate bits and nothing else.
    w_strb <= 4'h1;
    wr(CFG, 32'h1000);
    w_strb <= 4'hf;
    // An unaligned write is refused and leaves the register alone.
    wr(CFG | 18'h1, 32'h1abc);
    chk({30'h0, wresp}, {30'h0, `RESP_SLVERR});
    rc(CFG, 32'hf00);
    // No output before enough input strobes have passed.
    wr(MSK, 32'h3);
    wr(CFG, 32'h1002);
    hist.delete();
    repeat (300) @(posedge clk);
    rc(STA, 32'h0);
    run <= 1'b1;
    gap(12'h2);
    gap(12'h0);
    // Stop input, let unread updates pile up, then inspect.
    run <= 1'b0;
    repeat (600) @(posedge clk);
    wr(CFG, 32'h0);
    s = hist[hist.size() - D];
    rc(CFG, 32'he000);
    rc(LLO, lo(s.left));
    rc(LHI, hi(s.left));
    rc(CFG, 32'hc000);
    rc(RLO, lo(s.right));
    rc(RHI, hi(s.right));
    rc(CFG, 32'h8000);
    rc(STA, 32'h3);
    wr(CFG, 32'h8000);
    rc(CFG, 32'h0);
    // Disabled converter stays silent while input flows.
    wr(STA, 32'h3);
    run <= 1'b1;
    repeat (600) @(posedge clk);
    rc(STA, 32'h0);
    chk({31'h0, irq}, 32'h0);
    // Masked events stay in status without raising the line.
    wr(MSK, 32'h0);
    wr(CFG, 32'h1002);
    repeat (800) @(posedge clk);
    rc(STA, 32'h3);
    chk({31'h0, irq}, 32'h0);
    wr(MSK, 32'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    conclude();
  end
endmodule // audio_rate_upconverter_tb_top
